// ==== include/pic_params.svh ====
// Constants for the programmable input cell block.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
//
// Contract
// - Each input cell selects register, latch or flow-through, with shared or own clock.
// - The shared latch/clock pin always also feeds the logic array as input.
// - Synchronous cells use the shared pin as common enable or capture clock.
// - Asynchronous cells use their own dedicated product term as enable or clock.
// - Clock source is chosen per cell; both kinds coexist.
// - A latch whose enable term is held at one passes data straight through.
// - In synchronous mode capture or freeze happens on falling edge of shared pin.
// - Inputs and outputs start responding 6 to 10 us after power is applied; here SHARED_PIN_OUT follows its pin from reset.
// - Macrocells configured as registers come up holding zero.
// - Input registers are not initialised; contents undefined until first capture.
// - At power-up, input latches present current pin levels.
// - A power-down inhibit bit governs automatic standby.
// - With the inhibit bit set, standby is never entered.
// - With inhibit clear, standby follows 100 ns without any logic transition.
// - Once lock is programmed, configuration readback is refused.
// - Erase clears the lock bit with all other configuration; here erase clears only the lock bit and CELL_CFG is left untouched.
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_CLK_PERIOD_NS 10
`define PIC_PWRUP_MIN_US 6
`define PIC_PWRUP_MAX_US 10
// Power-up wait uses the least time, rounded up
`define PIC_PWRUP_CYCLES ((`PIC_PWRUP_MIN_US * 1000 + `PIC_CLK_PERIOD_NS - 1) / `PIC_CLK_PERIOD_NS)
`define PIC_IDLE_NS 100
`define PIC_IDLE_CYCLES ((`PIC_IDLE_NS + `PIC_CLK_PERIOD_NS - 1) / `PIC_CLK_PERIOD_NS)
`define PIC_NUM_INPUTS 8
`define PIC_CFG_RESET 3'h0
`endif

// ==== include/pic_pkg.sv ====
// Types shared by the programmable input cell block.
// Assumes pic_params.svh is on the include path.
package pic_pkg;
   // Mode bits: element kind and clock source
   typedef enum logic [1:0] {
      PIC_FLOW = 2'b00,
      PIC_REG = 2'b01,
      PIC_LATCH = 2'b10
   } pic_kind_e;
   typedef struct packed {
      pic_kind_e kind;
      logic async_src;
   } pic_cfg_s;
   // Power sequencing states, Gray along the path
   typedef enum logic [1:0] {
      PIC_ST_OFF = 2'b00,
      PIC_ST_WAIT = 2'b01,
      PIC_ST_RUN = 2'b11,
      PIC_ST_STBY = 2'b10
   } pic_state_e;
endpackage : pic_pkg

// ==== verification/pic_board.sv ====
// Board model: drives the device input pins from levels the bench asks for.
// Assumes requests change at rising CLK edges; the pins follow one edge later.
`timescale 1ns/1ps
`default_nettype none
module pic_board #(
   parameter int N = 8
) (
   input wire logic clk,
   input wire logic [N-1:0] want_pins,
   input wire logic want_shared,
   output logic [N-1:0] pins = '0,
   output logic shared_pin = 1'b0
);
   // One edge of board delay, so pins never move in the sampling step
   always @(posedge clk) begin
      pins <= want_pins;
      shared_pin <= want_shared;
   end
endmodule : pic_board
`default_nettype wire

// ==== verification/pic_top_test.sv ====
// Self-checking bench for the programmable input cells.
// Assumes pic_board drives the pins; product terms and settings come from here.
`timescale 1ns/1ps
`default_nettype none
module pic_top_test;
   import pic_pkg::*;
   localparam int N = 8;
   localparam int PW = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] wp = 8'ha5;
   logic ws = 1'b0;
   logic [7:0] pterm = 8'h20;
   logic [23:0] cfg = 24'h2a_d8d0;
   logic pdi = 1'b1;
   logic lock = 1'b0;
   logic erase = 1'b0;
   logic req = 1'b0;
   logic [7:0] pins, cell_out, exp, m, pen;
   logic spin, shared_out, macro, ready, stby, locked, rb_v;
   logic [23:0] rb_d;
   int failures = 0;
   int checks_done = 0;
   int n;
   pic_board #(.N(N)) board (.clk(clk), .want_pins(wp), .want_shared(ws), .pins(pins), .shared_pin(spin));
   pic_top #(.N(N), .PWRUP_CYCLES(PW)) uut (.CLK(clk), .SYS_RST(rst), .INPUT_PINS(pins),
      .SHARED_LATCH_CLOCK_PIN(spin), .CELL_PTERM(pterm), .CELL_CFG(cfg), .PD_INHIBIT(pdi),
      .LOCK_PROGRAM(lock), .ERASE(erase), .READBACK_REQ(req), .CELL_OUT(cell_out),
      .SHARED_PIN_OUT(shared_out), .MACRO_REG_OUT(macro), .READY(ready), .STANDBY(stby),
      .LOCKED(locked), .READBACK_VALID(rb_v), .READBACK_DATA(rb_d));
   always #5 clk = ~clk;
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   // Apply pin, shared pin and product-term levels, then compare every defined cell
   task automatic step(input logic [7:0] p, input logic s, input logic [7:0] t);
      logic [7:0] en;
      logic [1:0] k;
      wp <= p;
      ws <= s;
      pterm <= t;
      repeat (8) @(posedge clk);
      for (int i = 0; i < N; i++) begin
         k = cfg[3*i+1 +: 2];
         en[i] = cfg[3*i] ? t[i] : s;
         if (k == PIC_FLOW || (k == PIC_LATCH && en[i]) || (k == PIC_REG && pen[i] && !en[i])) begin
            exp[i] = p[i];
            m[i] = 1'b1;
         end
      end
      pen = en;
      #1;
      chk("cells", exp & m, cell_out & m);
      chk("shared_pin", s, shared_out);
      if (&m) chk("macro_reg", ^exp, macro);
   endtask : step
   // Pulse a readback request and collect any answer within four cycles
   task automatic rb(input logic e_v);
      logic v;
      logic [23:0] d;
      v = 1'b0;
      d = '0;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      repeat (4) begin
         @(posedge clk);
         #1;
         if (rb_v === 1'b1) begin
            v = 1'b1;
            d = rb_d;
         end
      end
      chk("rb_valid", e_v, v);
      chk("rb_data", e_v ? cfg : 24'h00_0000, d);
   endtask : rb
   // Watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      give_verdict();
   end
   initial begin
      exp = 8'ha5;
      m = 8'hb9;
      pen = 8'h20;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("macro_reg", 1'b0, macro);
      chk("cells_early", 8'h00, cell_out);
      for (n = 0; n < 100 && ready !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk("ready_time", 1'b1, n >= PW - 2 && n <= PW + 4);
      step(8'ha5, 1'b0, 8'h20);
      step(8'h5a, 1'b0, 8'h20);
      step(8'h5a, 1'b1, 8'h34);
      step(8'h5a, 1'b0, 8'h20);
      step(8'hff, 1'b0, 8'h20);
      step(8'hff, 1'b1, 8'h20);
      step(8'h00, 1'b1, 8'h20);
      step(8'h00, 1'b0, 8'h24);
      step(8'h00, 1'b0, 8'h20);
      step(8'hff, 1'b0, 8'h20);
      rb(1'b1);
      lock <= 1'b1;
      @(posedge clk);
      lock <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("locked", 1'b1, locked);
      rb(1'b0);
      erase <= 1'b1;
      @(posedge clk);
      erase <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("locked", 1'b0, locked);
      rb(1'b1);
      pdi <= 1'b0;
      wp <= 8'h0f;
      repeat (5) @(posedge clk);
      #1;
      chk("standby_early", 1'b0, stby);
      repeat (15) @(posedge clk);
      #1;
      chk("standby", 1'b1, stby);
      wp <= 8'hf0;
      repeat (8) @(posedge clk);
      #1;
      chk("standby_wake", 1'b0, stby);
      pdi <= 1'b1;
      repeat (30) @(posedge clk);
      #1;
      chk("standby_inhibit", 1'b0, stby);
      give_verdict();
   end
endmodule : pic_top_test
`default_nettype wire

// ==== verilog/pic_cell.sv ====
// One programmable input cell: register, latch or flow-through.
// Assumes pin and enable already synchronised to CLK; edges seen as sampled changes.
`timescale 1ns/1ps
`default_nettype none
module pic_cell
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic pin,
   input wire logic en,
   input wire logic en_prev,
   input wire logic pwr_on,
   input wire pic_cfg_s cfg,
   output logic data_out
);
   logic store;
   logic next_store;
   logic fall;

   assign fall = en_prev & ~en;

   // Next stored value per mode
   always_comb begin
      next_store = store;
      if (pwr_on) begin
         if (cfg.kind == PIC_LATCH) begin
            next_store = pin;
         end
      end else if (cfg.kind == PIC_REG) begin
         if (fall) begin
            next_store = pin;
         end
      end else if (cfg.kind == PIC_LATCH) begin
         if (en) begin
            next_store = pin;
         end
      end
   end

   // No reset here: register contents stay undefined until first capture
   always_ff @(posedge clk) begin
      store <= next_store;
   end

   // Latch is transparent while enabled; flow passes pin
   always_comb begin
      if (cfg.kind == PIC_FLOW) begin
         data_out = pin;
      end else if (cfg.kind == PIC_LATCH && en) begin
         data_out = pin;
      end else begin
         data_out = store;
      end
   end
endmodule : pic_cell
`default_nettype wire

// ==== verilog/pic_top.sv ====
// Programmable input stage with power-up, standby and readback lock.
// Assumes board pins are asynchronous; configuration comes from plain ports.
`timescale 1ns/1ps
`default_nettype none
`include "pic_params.svh"
module pic_top
   import pic_pkg::*;
#(
   parameter int N = `PIC_NUM_INPUTS,
   parameter int PWRUP_CYCLES = `PIC_PWRUP_CYCLES
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic [N-1:0] INPUT_PINS,
   input wire logic SHARED_LATCH_CLOCK_PIN,
   input wire logic [N-1:0] CELL_PTERM,
   input wire logic [3*N-1:0] CELL_CFG,
   input wire logic PD_INHIBIT,
   input wire logic LOCK_PROGRAM,
   input wire logic ERASE,
   input wire logic READBACK_REQ,
   output logic [N-1:0] CELL_OUT,
   output logic SHARED_PIN_OUT,
   output logic MACRO_REG_OUT,
   output logic READY,
   output logic STANDBY,
   output logic LOCKED,
   output logic READBACK_VALID,
   output logic [3*N-1:0] READBACK_DATA
);
   localparam int IDLE_CYCLES = `PIC_IDLE_CYCLES;
   localparam int PW = $clog2(PWRUP_CYCLES + 1);
   localparam int IW = $clog2(IDLE_CYCLES + 1);

   logic [N:0] sync1;
   logic [N:0] sync2;
   logic [N:0] sync3;
   logic [N-1:0] pt1;
   logic [N-1:0] pt2;
   logic [N-1:0] pt3;
   pic_state_e state, next_state;
   logic [PW-1:0] pcnt, next_pcnt;
   logic [IW-1:0] icnt, next_icnt;
   logic lock, next_lock;
   logic rb_valid, next_rb_valid;
   logic [3*N-1:0] rb_data, next_rb_data;
   logic [N-1:0] cell_val;
   logic activity;
   logic pwr_on;
   logic [N-1:0] next_cell_out;
   logic next_shared_out;
   logic next_macro_out;
   logic next_ready;
   logic next_standby;

   // Two-flop synchronisers, third stage only for edge history
   always_ff @(posedge CLK) begin
      sync1 <= {SHARED_LATCH_CLOCK_PIN, INPUT_PINS};
      sync2 <= sync1;
      sync3 <= sync2;
      pt1 <= CELL_PTERM;
      pt2 <= pt1;
      pt3 <= pt2;
   end

   assign pwr_on = (state == PIC_ST_WAIT);

   // Per-cell enable source chosen by its own config bit
   generate
      for (genvar i = 0; i < N; i++) begin : g_cell
         pic_cfg_s c;
         logic en;
         logic en_prev;
         assign c = pic_cfg_s'(CELL_CFG[3*i +: 3]);
         assign en = c.async_src ? pt2[i] : sync2[N];
         assign en_prev = c.async_src ? pt3[i] : sync3[N];
         pic_cell u_cell (
            .clk(CLK),
            .pin(sync2[i]),
            .en(en),
            .en_prev(en_prev),
            .pwr_on(pwr_on),
            .cfg(c),
            .data_out(cell_val[i])
         );
      end
   endgenerate

   assign activity = (sync2 != sync3) || (pt2 != pt3);

   // Power sequencing and standby
   always_comb begin
      next_state = state;
      next_pcnt = pcnt;
      next_icnt = icnt;
      case (state)
         PIC_ST_OFF: begin
            next_state = PIC_ST_WAIT;
            next_pcnt = '0;
         end
         PIC_ST_WAIT: begin
            next_pcnt = pcnt + PW'(1);
            if (pcnt >= PW'(PWRUP_CYCLES - 1)) begin
               next_state = PIC_ST_RUN;
               next_icnt = '0;
            end
         end
         PIC_ST_RUN: begin
            if (activity || PD_INHIBIT) begin
               next_icnt = '0;
            end else if (icnt >= IW'(IDLE_CYCLES - 1)) begin
               next_state = PIC_ST_STBY;
            end else begin
               next_icnt = icnt + IW'(1);
            end
         end
         default: begin
            // Any transition or inhibit wakes the device
            if (activity || PD_INHIBIT) begin
               next_state = PIC_ST_RUN;
               next_icnt = '0;
            end
         end
      endcase
   end

   // Lock and readback; erase outranks program
   always_comb begin
      next_lock = lock;
      if (ERASE) begin
         next_lock = 1'b0;
      end else if (LOCK_PROGRAM) begin
         next_lock = 1'b1;
      end
      next_rb_valid = 1'b0;
      next_rb_data = '0;
      if (READBACK_REQ && !lock && !ERASE) begin
         next_rb_valid = 1'b1;
         next_rb_data = CELL_CFG;
      end else if (READBACK_REQ) begin
         next_rb_valid = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state <= PIC_ST_OFF;
         pcnt <= '0;
         icnt <= '0;
         lock <= 1'b0;
         rb_valid <= 1'b0;
         rb_data <= '0;
      end else begin
         state <= next_state;
         pcnt <= next_pcnt;
         icnt <= next_icnt;
         lock <= next_lock;
         rb_valid <= next_rb_valid;
         rb_data <= next_rb_data;
      end
   end

   // Output next values; cells stay quiet until the power-up window ends
   always_comb begin
      next_ready = (state == PIC_ST_RUN) || (state == PIC_ST_STBY);
      next_cell_out = next_ready ? cell_val : '0;
      next_shared_out = sync2[N];
      // Stand-in macrocell register: parity of the cells, zero until ready
      next_macro_out = next_ready ? ^cell_val : 1'b0;
      next_standby = (state == PIC_ST_STBY);
   end

   // Every top-level output comes straight from this register stage
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         CELL_OUT <= '0;
         SHARED_PIN_OUT <= 1'b0;
         MACRO_REG_OUT <= 1'b0;
         READY <= 1'b0;
         STANDBY <= 1'b0;
         LOCKED <= 1'b0;
         READBACK_VALID <= 1'b0;
         READBACK_DATA <= '0;
      end else begin
         READY <= next_ready;
         CELL_OUT <= next_cell_out;
         SHARED_PIN_OUT <= next_shared_out;
         MACRO_REG_OUT <= next_macro_out;
         STANDBY <= next_standby;
         LOCKED <= lock;
         READBACK_VALID <= rb_valid;
         READBACK_DATA <= rb_data;
      end
   end

   // Standby never shows while inhibit has been high for two cycles
   AST_NO_STBY_INHIBIT: assert property (@(posedge CLK) disable iff (SYS_RST)
      PD_INHIBIT && $past(PD_INHIBIT) |=> !STANDBY) else $error("standby while inhibited");
   AST_PWRUP_READY: assert property (@(posedge CLK) disable iff (SYS_RST)
      $rose(state == PIC_ST_WAIT) |-> !READY [*8]) else $error("ready too early");
   AST_LOCK_REFUSE: assert property (@(posedge CLK) disable iff (SYS_RST)
      lock && READBACK_REQ |=> !rb_valid) else $error("readback while locked");
   AST_ERASE_UNLOCK: assert property (@(posedge CLK) disable iff (SYS_RST)
      ERASE |=> !lock) else $error("erase kept lock");
   AST_LOCK_SET: assert property (@(posedge CLK) disable iff (SYS_RST)
      LOCK_PROGRAM && !ERASE |=> ##1 LOCKED) else $error("lock not shown");
   AST_STBY_IDLE: assert property (@(posedge CLK) disable iff (SYS_RST)
      (state == PIC_ST_RUN) && !PD_INHIBIT && !activity && (icnt == IW'(IDLE_CYCLES - 1))
      |=> state == PIC_ST_STBY) else $error("standby not entered");
   AST_WAKE: assert property (@(posedge CLK) disable iff (SYS_RST)
      (state == PIC_ST_STBY) && activity |=> state == PIC_ST_RUN) else $error("no wake");
   AST_SHARED_IN: assert property (@(posedge CLK) disable iff (SYS_RST)
      ##1 SHARED_PIN_OUT == $past(sync2[N])) else $error("shared pin not passed");
   // Lock holds until an erase, and a locked readback never reaches the pins
   AST_LOCK_HOLD: assert property (@(posedge CLK) disable iff (SYS_RST)
      lock && !ERASE |=> lock) else $error("lock lost without erase");
   AST_RB_LOCKED_OUT: assert property (@(posedge CLK) disable iff (SYS_RST)
      lock && READBACK_REQ |=> ##1 !READBACK_VALID) else $error("readback shown while locked");
   AST_RB_ANSWER: assert property (@(posedge CLK) disable iff (SYS_RST)
      READBACK_REQ && !lock && !ERASE |=> ##1 READBACK_VALID) else $error("readback not answered");
   // CELL_OUT and STANDBY stay low before the power-up window ends
   AST_CELLS_QUIET: assert property (@(posedge CLK) disable iff (SYS_RST)
      !READY |-> CELL_OUT == '0) else $error("cells shown before power-up");
   AST_STBY_READY: assert property (@(posedge CLK) disable iff (SYS_RST)
      STANDBY |-> READY) else $error("standby before power-up");
endmodule : pic_top
`default_nettype wire
